/* core/tmc_regs.svh */
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// High-temperature limit in tenths of a degree Celsius.
`define TMC_THI_MIN 12'h000
`define TMC_THI_MAX 12'h7cf
`define TMC_THI_RST 12'h3e8
// Current limit in milliamperes.
`define TMC_ILIM_RST 16'h07d0
// Shutdown-enable bit of weight 8 is the high-temperature condition.
`define TMC_OFF_RST 16'h0008
`define TMC_HT_BIT 3
// Mode codes.
`define TMC_MODE_ITE 2'h0
`define TMC_MODE_R 2'h1
`define TMC_MODE_T 2'h2
// Command opcodes.
`define TMC_OP_NONE 4'h0
`define TMC_OP_QLIM_I 4'h1
`define TMC_OP_SLIM_I 4'h2
`define TMC_OP_QTHI 4'h3
`define TMC_OP_STHI 4'h4
`define TMC_OP_QMODE 4'h5
`define TMC_OP_MODE_I 4'h6
`define TMC_OP_MODE_R 4'h7
`define TMC_OP_MODE_T 4'h8
`define TMC_OP_OUT 4'h9
`define TMC_OP_QOUT 4'ha
`define TMC_OP_SOFF 4'hb
// Mode reply characters.
`define TMC_CH_I 24'h495445
`define TMC_CH_R 24'h000052
`define TMC_CH_T 24'h000054
// Parameter indicator codes.
`define TMC_PLED_ILIM 2'h1
`define TMC_PLED_THI 2'h2
// Event bit set by a high-temperature trip.
`define TMC_EV_RST 16'h0000

`endif

/* core/tmc_pkg.sv */
package tmc_pkg;
    typedef logic [1:0] tmc_mode_t;
    typedef enum logic [1:0] {
        TMC_P_ILIM = 2'b00,
        TMC_P_THI = 2'b01
    } tmc_par_t;
    typedef enum logic [1:0] {
        TMC_S_IDLE = 2'b00,
        TMC_S_EXEC = 2'b01,
        TMC_S_REPLY = 2'b10
    } tmc_state_t;
endpackage : tmc_pkg

/* core/tmc_edge.sv */
`timescale 1ns/1ps
// Rising-edge detector for a front-panel switch, one pulse per press.
module tmc_edge
    import tmc_pkg::*;
#(
    parameter int N = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Switch levels and press pulses.
    input wire logic [N-1:0] lvl,
    output logic [N-1:0] press
);
    logic [N-1:0] prev_ff;
    logic [N-1:0] nxt_prev;

    always_comb begin
        nxt_prev = lvl;
        press = lvl & ~prev_ff;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= nxt_prev;
        end
    end
endmodule : tmc_edge

/* core/tmc_ctrl.sv */
`timescale 1ns/1ps
`include "tmc_regs.svh"
// Overview of operation
// - Current-limit query returns stored milliamperes value.
// - Temperature limit accepted only 0 to 199.9.
// - Reaching the limit switches output off.
// - Limit check only in R and T.
// - Output-on refused while over limit.
// - Mode query answers ITE, R or T.
// - Mode selects the regulated quantity.
// - Current mode regulates drive current.
// - Mode change forces output off, shows set point; a panel output press in the same cycle as a remote change toggles it back on.
// - Resistance mode uses set point directly.
// - Temperature mode converts set point first.
// - Output command: 1 on, 0 off.
// - Panel output switch toggles output.
// - Panel mode switch advances mode, lights indicator.
// - Panel parameter switch advances shown parameter.
// - Weight-8 bit is high-temperature condition.
// - Output query returns 0 off, 1 on.
module tmc_ctrl
    import tmc_pkg::*;
#(
    parameter int TW = 12,
    parameter int DW = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host command.
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [DW-1:0] cmd_arg,
    // Host reply.
    output logic rsp_valid,
    output logic [23:0] rsp_data,
    output logic cmd_err,
    // Front-panel switches, high while pressed.
    input wire logic sw_out,
    input wire logic sw_mode,
    input wire logic sw_par,
    // Measured load temperature, tenths of a degree Celsius.
    input wire logic [TW-1:0] load_temp,
    // Loop and display.
    output logic out_on,
    output logic [1:0] mode,
    output logic [2:0] mode_led,
    output logic [1:0] par_led,
    output logic show_setpt,
    output logic use_conv,
    output logic [DW-1:0] ilim,
    output logic [TW-1:0] thi,
    output logic [DW-1:0] event_bits
);
    // The limit and reply fields are sized for these minimum widths.
    if (TW < 12) begin : g_tw_check
        $error("tmc_ctrl: TW below 12");
    end
    if (DW < 16) begin : g_dw_check
        $error("tmc_ctrl: DW below 16");
    end

    logic [2:0] press;
    tmc_state_t st_ff, nxt_st;
    logic [3:0] op_ff, nxt_op;
    logic [DW-1:0] arg_ff, nxt_arg;
    tmc_mode_t mode_ff, nxt_mode;
    logic out_ff, nxt_out;
    logic [DW-1:0] ilim_ff, nxt_ilim;
    logic [TW-1:0] thi_ff, nxt_thi;
    logic [DW-1:0] off_en_ff, nxt_off_en;
    logic [DW-1:0] ev_ff, nxt_ev;
    tmc_par_t par_ff, nxt_par;
    logic rv_ff, nxt_rv;
    logic [23:0] rd_ff, nxt_rd;
    logic err_ff, nxt_err;
    logic show_ff, nxt_show;
    logic trip;

    tmc_edge #(.N(3)) u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .lvl({sw_par, sw_mode, sw_out}),
        .press(press)
    );

    function automatic logic in_window(input tmc_mode_t m);
        in_window = (m == `TMC_MODE_R) || (m == `TMC_MODE_T);
    endfunction : in_window

    function automatic logic hot(input tmc_mode_t m,
                                 input logic [TW-1:0] t,
                                 input logic [TW-1:0] lim,
                                 input logic [DW-1:0] en);
        hot = in_window(m) && en[`TMC_HT_BIT] && (t >= lim);
    endfunction : hot

    function automatic tmc_mode_t next_mode(input tmc_mode_t m);
        next_mode = (m == `TMC_MODE_T) ? `TMC_MODE_ITE : m + 2'h1;
    endfunction : next_mode

    // Maps a mode command onto its stored mode code.
    function automatic tmc_mode_t cmd_mode(input logic [3:0] op);
        if (op == `TMC_OP_MODE_I) begin
            cmd_mode = `TMC_MODE_ITE;
        end else if (op == `TMC_OP_MODE_R) begin
            cmd_mode = `TMC_MODE_R;
        end else begin
            cmd_mode = `TMC_MODE_T;
        end
    endfunction : cmd_mode

    assign trip = hot(mode_ff, load_temp, thi_ff, off_en_ff);

    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_arg = arg_ff;
        nxt_mode = mode_ff;
        nxt_out = out_ff;
        nxt_ilim = ilim_ff;
        nxt_thi = thi_ff;
        nxt_off_en = off_en_ff;
        nxt_ev = ev_ff;
        nxt_par = par_ff;
        nxt_rv = 1'b0;
        nxt_rd = rd_ff;
        nxt_err = 1'b0;
        nxt_show = 1'b0;
        case (st_ff)
            TMC_S_IDLE: begin
                if (cmd_valid) begin
                    nxt_op = cmd_op;
                    nxt_arg = cmd_arg;
                    nxt_st = TMC_S_EXEC;
                end
            end
            TMC_S_EXEC: begin
                nxt_st = TMC_S_IDLE;
                if (op_ff == `TMC_OP_QLIM_I) begin
                    nxt_rd = {8'h00, ilim_ff[15:0]};
                    nxt_st = TMC_S_REPLY;
                end else if (op_ff == `TMC_OP_SLIM_I) begin
                    nxt_ilim = arg_ff;
                end else if (op_ff == `TMC_OP_QTHI) begin
                    nxt_rd = {12'h000, thi_ff[11:0]};
                    nxt_st = TMC_S_REPLY;
                end else if (op_ff == `TMC_OP_STHI) begin
                    if (arg_ff[TW-1:0] <= `TMC_THI_MAX
                        && arg_ff[DW-1:TW] == '0) begin
                        nxt_thi = arg_ff[TW-1:0];
                    end else begin
                        nxt_err = 1'b1;
                    end
                end else if (op_ff == `TMC_OP_QMODE) begin
                    case (mode_ff)
                        `TMC_MODE_ITE: nxt_rd = `TMC_CH_I;
                        `TMC_MODE_R: nxt_rd = `TMC_CH_R;
                        default: nxt_rd = `TMC_CH_T;
                    endcase
                    nxt_st = TMC_S_REPLY;
                end else if (op_ff == `TMC_OP_MODE_I
                             || op_ff == `TMC_OP_MODE_R
                             || op_ff == `TMC_OP_MODE_T) begin
                    nxt_mode = cmd_mode(op_ff);
                    // Reselecting the active mode leaves the output alone.
                    if (nxt_mode != mode_ff) begin
                        nxt_out = 1'b0;
                        nxt_show = 1'b1;
                    end
                end else if (op_ff == `TMC_OP_OUT) begin
                    // Arguments other than 0 and 1 are refused, not guessed.
                    if (arg_ff == 16'h0001) begin
                        if (trip) begin
                            nxt_err = 1'b1;
                        end else begin
                            nxt_out = 1'b1;
                        end
                    end else if (arg_ff == 16'h0000) begin
                        nxt_out = 1'b0;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end else if (op_ff == `TMC_OP_QOUT) begin
                    nxt_rd = {23'h0, out_ff};
                    nxt_st = TMC_S_REPLY;
                end else if (op_ff == `TMC_OP_SOFF) begin
                    // The whole mask is kept; only the limit bit acts here.
                    nxt_off_en = arg_ff;
                end else begin
                    nxt_err = 1'b1;
                end
            end
            TMC_S_REPLY: begin
                // Data settled a cycle earlier, so valid meets a still word.
                nxt_rv = 1'b1;
                nxt_st = TMC_S_IDLE;
            end
            default: nxt_st = TMC_S_IDLE;
        endcase
        // Panel presses act after remote commands in the same cycle.
        if (press[0]) begin
            nxt_out = trip ? 1'b0 : ~nxt_out;
        end
        if (press[1]) begin
            nxt_mode = next_mode(nxt_mode);
            nxt_out = 1'b0;
            nxt_show = 1'b1;
        end
        if (press[2]) begin
            nxt_par = (par_ff == TMC_P_ILIM) ? TMC_P_THI : TMC_P_ILIM;
        end
        // The trip wins over any turn-on, so a hot load never starts in R or T while the weight-8 enable bit is set.
        if (hot(nxt_mode, load_temp, nxt_thi, nxt_off_en)) begin
            nxt_out = 1'b0;
        end
        // Sticky until reset, since nothing here reads and clears it.
        if (trip && in_window(mode_ff)) begin
            nxt_ev[`TMC_HT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= TMC_S_IDLE;
            op_ff <= `TMC_OP_NONE;
            arg_ff <= '0;
            mode_ff <= `TMC_MODE_ITE;
            out_ff <= 1'b0;
            ilim_ff <= `TMC_ILIM_RST;
            thi_ff <= `TMC_THI_RST;
            off_en_ff <= `TMC_OFF_RST;
            ev_ff <= `TMC_EV_RST;
            par_ff <= TMC_P_ILIM;
            rv_ff <= 1'b0;
            rd_ff <= '0;
            err_ff <= 1'b0;
            show_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            arg_ff <= nxt_arg;
            mode_ff <= nxt_mode;
            out_ff <= nxt_out;
            ilim_ff <= nxt_ilim;
            thi_ff <= nxt_thi;
            off_en_ff <= nxt_off_en;
            ev_ff <= nxt_ev;
            par_ff <= nxt_par;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            err_ff <= nxt_err;
            show_ff <= nxt_show;
        end
    end

    // Mode steers the loop: constant current, direct R, or converted T.
    logic [2:0] led_ff, nxt_led;
    logic conv_ff, nxt_conv;
    always_comb begin
        nxt_led = 3'h1 << nxt_mode;
        nxt_conv = (nxt_mode == `TMC_MODE_T);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            led_ff <= 3'h1;
            conv_ff <= 1'b0;
        end else begin
            led_ff <= nxt_led;
            conv_ff <= nxt_conv;
        end
    end

    // Parameter indicator, registered so the panel never sees a glitch.
    logic [1:0] pled_ff, nxt_pled;
    always_comb begin
        nxt_pled = (nxt_par == TMC_P_ILIM) ? `TMC_PLED_ILIM : `TMC_PLED_THI;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pled_ff <= `TMC_PLED_ILIM;
        end else begin
            pled_ff <= nxt_pled;
        end
    end

    assign rsp_valid = rv_ff;
    assign rsp_data = rd_ff;
    assign cmd_err = err_ff;
    assign out_on = out_ff;
    assign mode = mode_ff;
    assign mode_led = led_ff;
    assign par_led = pled_ff;
    assign show_setpt = show_ff;
    assign use_conv = conv_ff;
    assign ilim = ilim_ff;
    assign thi = thi_ff;
    assign event_bits = ev_ff;
endmodule : tmc_ctrl

/* verification/tmc_ctrl_assertions.sv */
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_ctrl_chk #(
    parameter int TW = 12,
    parameter int DW = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host side.
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic rsp_valid,
    input wire logic [TW-1:0] load_temp,
    // State outputs.
    input wire logic out_on,
    input wire logic [1:0] mode,
    input wire logic [2:0] mode_led,
    input wire logic [1:0] par_led,
    input wire logic show_setpt,
    input wire logic use_conv,
    input wire logic [TW-1:0] thi,
    input wire logic [DW-1:0] event_bits
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_mode_off;
        !$stable(mode) |-> !out_on && show_setpt;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("mode change left output on");
    property p_conv;
        use_conv == (mode == `TMC_MODE_T);
    endproperty
    a_conv: assert property (p_conv)
        else $error("conversion flag wrong for mode");
    property p_trip;
        (mode != `TMC_MODE_ITE && load_temp >= thi) [*3] |-> !out_on;
    endproperty
    a_trip: assert property (p_trip)
        else $error("output on above temperature limit");
    property p_on_ok;
        $rose(out_on) |-> $past(mode == `TMC_MODE_ITE || load_temp < thi);
    endproperty
    a_on_ok: assert property (p_on_ok)
        else $error("output switched on above limit");
    property p_ev;
        event_bits[`TMC_HT_BIT] |=> event_bits[`TMC_HT_BIT];
    endproperty
    a_ev: assert property (p_ev)
        else $error("high temperature event lost");
    property p_rsp;
        rsp_valid |-> $past(cmd_valid, 3) && !$past(rsp_valid);
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("reply not three cycles after command");
    property p_thi;
        !$stable(thi) |-> $past(cmd_valid, 2) &&
            $past(cmd_op, 2) == `TMC_OP_STHI && thi <= `TMC_THI_MAX;
    endproperty
    a_thi: assert property (p_thi)
        else $error("limit changed without valid write");
    property p_led;
        mode_led == (3'h1 << mode) && $onehot(par_led);
    endproperty
    a_led: assert property (p_led)
        else $error("indicator does not match selection");
endmodule : tmc_ctrl_chk

bind tmc_ctrl tmc_ctrl_chk #(.TW(TW), .DW(DW)) i_chk (.clk, .rst_n,
    .cmd_valid, .cmd_op, .rsp_valid, .load_temp, .out_on, .mode,
    .mode_led, .par_led, .show_setpt, .use_conv, .thi, .event_bits);

/* verification/tmc_host.sv */
`timescale 1ns/1ps
module tmc_host (
    // Clock.
    input wire logic clk,
    // Command and reply.
    output logic cmd_valid = 1'b0,
    output logic [3:0] cmd_op = 4'h0,
    output logic [15:0] cmd_arg = 16'h0000,
    input wire logic rsp_valid,
    input wire logic [23:0] rsp_data,
    input wire logic cmd_err,
    // Panel switches and load sensor.
    output logic [2:0] sw = 3'h0,
    output logic [11:0] load_temp = 12'h000
);
    // The host does not wait for tolerance after switching on.
    // Arguments are in range unless a test asks otherwise.
    task automatic run(input logic [3:0] op, input logic [15:0] arg,
                       output logic [23:0] rsp, output logic err);
        cmd_op <= op;
        cmd_arg <= arg;
        cmd_valid <= 1'b1;
        err = 1'b0;
        rsp = 24'hxxxxxx;
        repeat (4) begin
            @(posedge clk);
            cmd_valid <= 1'b0;
            // Unqualified lines carry garbage so stale values never pass.
            cmd_op <= ~op;
            cmd_arg <= ~arg;
            #1;
            err = err | cmd_err;
            if (rsp_valid === 1'b1) begin
                rsp = rsp_data;
            end
        end
        @(posedge clk);
    endtask : run

    task automatic press(input int idx);
        sw[idx] <= 1'b1;
        repeat (3) @(posedge clk);
        sw[idx] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : press
endmodule : tmc_host

/* verification/tb_tec_mode_limit_output_control.sv */
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tb_tec_mode_limit_output_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int show_cnt = 0;
    int show_base;
    logic [23:0] rsp;
    logic err;
    logic cmd_valid, rsp_valid, cmd_err, out_on, show_setpt, use_conv;
    logic [3:0] cmd_op;
    logic [15:0] cmd_arg, ilim, event_bits;
    logic [23:0] rsp_data;
    logic [2:0] sw, mode_led;
    logic [11:0] load_temp, thi;
    logic [1:0] mode, par_led;
    logic [3:0] m_op [3] = '{`TMC_OP_MODE_R, `TMC_OP_MODE_T, `TMC_OP_MODE_I};
    logic [23:0] m_ch [3] = '{`TMC_CH_R, `TMC_CH_T, `TMC_CH_I};

    initial forever #2.5 clk = ~clk;

    // Counts set-point display pulses so each mode change shows exactly one.
    always @(posedge clk) show_cnt <= show_cnt + int'(show_setpt);

    tmc_ctrl i_dut (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_arg, .rsp_valid,
        .rsp_data, .cmd_err, .sw_out(sw[0]), .sw_mode(sw[1]),
        .sw_par(sw[2]), .load_temp, .out_on, .mode, .mode_led, .par_led,
        .show_setpt, .use_conv, .ilim, .thi, .event_bits);
    tmc_host i_host (.clk, .cmd_valid, .cmd_op, .cmd_arg, .rsp_valid,
        .rsp_data, .cmd_err, .sw, .load_temp);

    task automatic chk(input string nm, input logic [23:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // The full sequence needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("ilim", 24'(`TMC_ILIM_RST), 24'(ilim));
        chk("mode", 24'(`TMC_MODE_ITE), 24'(mode));
        chk("par_led", 24'h1, 24'(par_led));
        $display("test reset done");
        i_host.run(`TMC_OP_QLIM_I, 16'h0000, rsp, err);
        chk("ilim reply", 24'(`TMC_ILIM_RST), rsp);
        i_host.run(`TMC_OP_SLIM_I, 16'h0bb8, rsp, err);
        chk("ilim set", 24'h000bb8, 24'(ilim));
        i_host.run(`TMC_OP_QLIM_I, 16'h0000, rsp, err);
        chk("ilim reply set", 24'h000bb8, rsp);
        i_host.run(`TMC_OP_STHI, 16'h07cf, rsp, err);
        chk("thi max", 24'h7cf, 24'(thi));
        i_host.run(`TMC_OP_STHI, 16'h07d0, rsp, err);
        chk("thi reject", 24'h1, 24'(err));
        i_host.run(`TMC_OP_QTHI, 16'h0000, rsp, err);
        chk("thi kept", 24'h7cf, rsp);
        $display("test limits done");
        for (int v = 1; v >= 0; v--) begin
            i_host.run(`TMC_OP_OUT, 16'(v), rsp, err);
            chk("out_on", 24'(v), 24'(out_on));
            i_host.run(`TMC_OP_QOUT, 16'h0000, rsp, err);
            chk("out reply", 24'(v), rsp);
        end
        i_host.run(`TMC_OP_OUT, 16'h0002, rsp, err);
        chk("out bad arg", 24'h1, 24'(err));
        $display("test output done");
        for (int i = 0; i < 3; i++) begin
            i_host.run(`TMC_OP_OUT, 16'h0001, rsp, err);
            show_base = show_cnt;
            i_host.run(m_op[i], 16'h0000, rsp, err);
            chk("forced off", 24'h0, 24'(out_on));
            chk("show_setpt", 24'(show_base + 1), 24'(show_cnt));
            chk("mode", 24'((i + 1) % 3), 24'(mode));
            chk("use_conv", 24'(i == 1), 24'(use_conv));
            i_host.run(`TMC_OP_QMODE, 16'h0000, rsp, err);
            chk("mode reply", m_ch[i], rsp);
        end
        $display("test modes done");
        i_host.run(`TMC_OP_SOFF, 16'h0008, rsp, err);
        chk("soff accepted", 24'h0, 24'(err));
        i_host.run(`TMC_OP_STHI, 16'h03e8, rsp, err);
        i_host.run(`TMC_OP_MODE_T, 16'h0000, rsp, err);
        i_host.run(`TMC_OP_OUT, 16'h0001, rsp, err);
        chk("on below limit", 24'h1, 24'(out_on));
        i_host.load_temp <= 12'h3e8;
        repeat (4) @(posedge clk);
        chk("trip off", 24'h0, 24'(out_on));
        chk("event", 24'h1, 24'(event_bits[`TMC_HT_BIT]));
        i_host.run(`TMC_OP_OUT, 16'h0001, rsp, err);
        chk("on refused", 24'h0, 24'(out_on));
        i_host.run(`TMC_OP_MODE_I, 16'h0000, rsp, err);
        i_host.run(`TMC_OP_OUT, 16'h0001, rsp, err);
        chk("no check in ITE", 24'h1, 24'(out_on));
        show_base = show_cnt;
        i_host.run(`TMC_OP_MODE_I, 16'h0000, rsp, err);
        chk("same mode keeps on", 24'h1, 24'(out_on));
        chk("same mode no show", 24'(show_base), 24'(show_cnt));
        $display("test trip done");
        i_host.press(0);
        chk("panel toggle", 24'h0, 24'(out_on));
        i_host.press(0);
        chk("panel toggle", 24'h1, 24'(out_on));
        i_host.press(1);
        chk("panel mode", 24'(`TMC_MODE_R), 24'(mode));
        chk("mode led", 24'h2, 24'(mode_led));
        chk("panel off", 24'h0, 24'(out_on));
        i_host.press(2);
        chk("par_led", 24'h2, 24'(par_led));
        $display("test panel done");
        tally_and_finish();
    end
endmodule : tb_tec_mode_limit_output_control
